// ==== tgd_detector.sv ====
// module: tap gesture detector with apb register file
// Summary of operation
// - tap candidate when selected axis magnitude exceeds the eight-bit unsigned level
// - each level code weighs 500 mg; top meaningful level is twice range
// - level zero disables all tap detection and events
// - tap qualifies only if above level no longer than (duration + 1) x 625 us
// - after a tap, wait latency x 1.25 ms before the next-tap window
// - latency zero disables double tap; single tap still works
// - second tap counts as double only within window x 1.25 ms
// - setup bit 2 enables triple tap recognition
// - axis field 00 selects X, 01 Y, 10 Z
`timescale 1ns/10ps
module tgd_detector import tgd_pkg::*; #(
  parameter int DUR_TICK_CYC = TAP_PULSE_MAX_TIME_CYC,
  parameter int GAP_TICK_CYC = TAP_GAP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_valid,
  input wire logic signed [15:0] sample_x,
  input wire logic signed [15:0] sample_y,
  input wire logic signed [15:0] sample_z,
  input wire logic [1:0] meas_range,
  output logic single_tap,
  output logic double_tap,
  output logic triple_tap
);

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] dur;
    logic [7:0] quiet;
    logic [7:0] win;
    logic [2:0] setup;
    logic [2:0] sticky;
    tgd_state_t st;
    logic [1:0] taps;
    logic [7:0] cnt;
    logic single;
    logic dbl;
    logic triple;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } tgd_regs_t;

  tgd_regs_t s;
  tgd_regs_t next_s;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ---------------------------------------------------------------
  // tick generators
  // ---------------------------------------------------------------
  tgd_tick_if dur_if ();
  tgd_tick_if gap_if ();

  tgd_tick #(.CYCLES(DUR_TICK_CYC)) u_dur_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tk(dur_if.gen)
  );

  tgd_tick #(.CYCLES(GAP_TICK_CYC)) u_gap_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tk(gap_if.gen)
  );

  logic dur_tick;
  logic gap_tick;
  logic st_change;

  assign dur_tick = dur_if.tick;
  assign gap_tick = gap_if.tick;
  assign st_change = (next_s.st != s.st) || (next_s.taps != s.taps);
  assign dur_if.restart = st_change;
  assign gap_if.restart = st_change;

  // ---------------------------------------------------------------
  // axis select and threshold compare
  // ---------------------------------------------------------------
  logic signed [15:0] sel;
  logic axis_ok;
  logic [15:0] mag;
  logic [5:0] range_g;
  logic [21:0] scaled_mag;
  logic [21:0] scaled_lim;
  logic en;
  logic above;

  always_comb begin
    sel = sample_x;
    axis_ok = 1'b1;
    case (s.setup[1:0])
      TGD_AXIS_X: sel = sample_x;
      TGD_AXIS_Y: sel = sample_y;
      TGD_AXIS_Z: sel = sample_z;
      default: begin
        sel = 16'sh0000;
        axis_ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    case (meas_range)
      2'h0: range_g = TGD_RANGE_15G;
      2'h1: range_g = TGD_RANGE_30G;
      default: range_g = TGD_RANGE_60G;
    endcase
  end

  // compare |a| * range against level * 16384; both in units of g/32768
  assign mag = sel[15] ? 16'(-sel) : 16'(sel);
  assign scaled_mag = 22'(mag) * 22'(range_g);
  assign scaled_lim = 22'(s.level) * TGD_LEVEL_WEIGHT;
  assign en = (s.level != 8'h00) && axis_ok;
  assign above = en && (scaled_mag > scaled_lim);

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic acc;
  logic done;
  logic hit;
  logic [31:0] rd_val;
  logic [9:0] idx;

  assign acc = psel && penable;
  assign done = acc && s.ready;
  assign idx = paddr[11:2];

  always_comb begin
    hit = 1'b1;
    rd_val = 32'h00000000;
    case (idx)
      TGD_IDX_LEVEL: rd_val = {24'h000000, s.level};
      TGD_IDX_DUR: rd_val = {24'h000000, s.dur};
      TGD_IDX_QUIET: rd_val = {24'h000000, s.quiet};
      TGD_IDX_WIN: rd_val = {24'h000000, s.win};
      TGD_IDX_SETUP: rd_val = {29'h00000000, s.setup};
      TGD_IDX_STATUS: rd_val = {23'h000000, s.st, (s.st != ST_IDLE), s.sticky};
      default: hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [1:0] tap_rank;
  logic [8:0] cnt_inc;
  logic more_taps;

  always_comb begin
    next_s = s;
    next_s.single = 1'b0;
    next_s.dbl = 1'b0;
    next_s.triple = 1'b0;
    next_s.ready = 1'b0;
    next_s.err = 1'b0;
    cnt_inc = {1'b0, s.cnt} + 9'h001;
    tap_rank = s.taps;
    if ((s.quiet == 8'h00) || (s.taps == 2'h2 && !s.setup[TGD_TRIPLE_EN_BIT])) begin
      tap_rank = 2'h0;
    end
    more_taps = (s.quiet != 8'h00) &&
      ((tap_rank == 2'h0) || (tap_rank == 2'h1 && s.setup[TGD_TRIPLE_EN_BIT]));

    // one wait state: data and pready both registered
    if (acc && !s.ready) begin
      next_s.ready = 1'b1;
      next_s.err = !hit;
      next_s.rdata = pwrite ? 32'h00000000 : rd_val;
    end
    if (done && pwrite) begin
      case (idx)
        TGD_IDX_LEVEL: next_s.level = pwdata[7:0];
        TGD_IDX_DUR: next_s.dur = pwdata[7:0];
        TGD_IDX_QUIET: next_s.quiet = pwdata[7:0];
        TGD_IDX_WIN: next_s.win = pwdata[7:0];
        TGD_IDX_SETUP: next_s.setup = pwdata[2:0];
        TGD_IDX_STATUS: next_s.sticky = s.sticky & ~pwdata[2:0];
        default: ;
      endcase
    end

    case (s.st)
      ST_IDLE: begin
        next_s.taps = 2'h0;
        next_s.cnt = 8'h00;
        if (sample_valid && above) begin
          next_s.st = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (!en) begin
          next_s.st = ST_IDLE;
        end else if (sample_valid && !above) begin
          // pulse ended in time: a valid tap
          case (tap_rank)
            2'h0: next_s.single = 1'b1;
            2'h1: next_s.dbl = 1'b1;
            default: next_s.triple = 1'b1;
          endcase
          next_s.cnt = 8'h00;
          if (more_taps) begin
            next_s.st = ST_LATENT;
            next_s.taps = tap_rank + 2'h1;
          end else begin
            next_s.st = ST_IDLE;
            next_s.taps = 2'h0;
          end
        end else if (dur_tick) begin
          if (s.cnt == s.dur) begin
            next_s.st = ST_DROP;
          end else begin
            next_s.cnt = cnt_inc[7:0];
          end
        end
      end
      ST_DROP: begin
        // too long for a tap; wait for the signal to fall
        if (!en || (sample_valid && !above)) begin
          next_s.st = ST_IDLE;
          next_s.taps = 2'h0;
        end
      end
      ST_LATENT: begin
        if (!en || s.quiet == 8'h00) begin
          next_s.st = ST_IDLE;
        end else if (gap_tick) begin
          if (cnt_inc >= {1'b0, s.quiet}) begin
            next_s.cnt = 8'h00;
            next_s.st = (s.win == 8'h00) ? ST_IDLE : ST_WINDOW;
          end else begin
            next_s.cnt = cnt_inc[7:0];
          end
        end
      end
      ST_WINDOW: begin
        if (!en || s.quiet == 8'h00) begin
          next_s.st = ST_IDLE;
        end else if (sample_valid && above) begin
          next_s.st = ST_PULSE;
          next_s.cnt = 8'h00;
        end else if (gap_tick) begin
          if (cnt_inc >= {1'b0, s.win}) begin
            next_s.st = ST_IDLE;
          end else begin
            next_s.cnt = cnt_inc[7:0];
          end
        end
      end
      default: begin
        next_s.st = ST_IDLE;
        next_s.taps = 2'h0;
        next_s.cnt = 8'h00;
      end
    endcase

    // hardware set wins over software clear
    next_s.sticky = next_s.sticky | {next_s.triple, next_s.dbl, next_s.single};
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{level: TGD_RST_LEVEL, dur: TGD_RST_DUR, quiet: TGD_RST_QUIET,
             win: TGD_RST_WIN, setup: TGD_RST_SETUP, sticky: 3'h0, st: ST_IDLE,
             taps: 2'h0, cnt: 8'h00, single: 1'b0, dbl: 1'b0, triple: 1'b0,
             rdata: 32'h00000000, ready: 1'b0, err: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.rdata;
  assign pready = s.ready;
  assign pslverr = s.err;
  assign single_tap = s.single;
  assign double_tap = s.dbl;
  assign triple_tap = s.triple;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_level_zero: assert property (s.level == 8'h00 |=> !single_tap && !double_tap)
    else $error("tap event with zero level");

  chk_axis_none: assert property (s.setup[1:0] == 2'h3 |=> !single_tap && !triple_tap)
    else $error("tap event with no axis selected");

  chk_axis_map: assert property (s.setup[1:0] == TGD_AXIS_Y |-> sel == sample_y)
    else $error("axis select does not pick y");

  chk_tap_cause: assert property (single_tap |->
      $past(s.st == ST_PULSE && sample_valid && !above && en))
    else $error("single tap without falling pulse");

  chk_pulse_limit: assert property (s.st == ST_PULSE && en && !(sample_valid && !above)
      && dur_tick && s.cnt == s.dur |=> s.st == ST_DROP)
    else $error("overlong pulse not rejected");

  chk_latent_quiet: assert property (s.st == ST_LATENT |=> s.st != ST_PULSE)
    else $error("pulse accepted during latency");

  chk_no_double: assert property (double_tap |-> $past(s.quiet) != 8'h00)
    else $error("double tap with zero latency");

  chk_window_end: assert property (s.st == ST_WINDOW && en && s.quiet != 8'h00
      && !(sample_valid && above) && gap_tick && cnt_inc >= {1'b0, s.win}
      |=> s.st == ST_IDLE)
    else $error("window did not close");

  chk_triple_off: assert property (!s.setup[TGD_TRIPLE_EN_BIT] |=> !triple_tap)
    else $error("triple tap while disabled");

  chk_triple_rank: assert property (triple_tap |-> $past(s.taps) == 2'h2)
    else $error("triple tap without two prior taps");

  cov_single: cover property (single_tap);
  cov_double: cover property (double_tap);
  cov_triple: cover property (triple_tap);
  cov_reject: cover property (s.st == ST_DROP);

endmodule // tgd_detector

// ==== tgd_pkg.sv ====
// package: register map, field layout, timing and state codes of the tap detector
package tgd_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0] TGD_IDX_LEVEL = 10'h043;
  localparam logic [9:0] TGD_IDX_DUR = 10'h044;
  localparam logic [9:0] TGD_IDX_QUIET = 10'h045;
  localparam logic [9:0] TGD_IDX_WIN = 10'h046;
  localparam logic [9:0] TGD_IDX_SETUP = 10'h047;
  localparam logic [9:0] TGD_IDX_STATUS = 10'h050;

  // ---------------------------------------------------------------
  // reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] TGD_RST_LEVEL = 8'h00;
  localparam logic [7:0] TGD_RST_DUR = 8'h00;
  localparam logic [7:0] TGD_RST_QUIET = 8'h00;
  localparam logic [7:0] TGD_RST_WIN = 8'h00;
  localparam logic [2:0] TGD_RST_SETUP = 3'h0;
  localparam int TGD_TRIPLE_EN_BIT = 2;
  localparam logic [1:0] TGD_AXIS_X = 2'h0;
  localparam logic [1:0] TGD_AXIS_Y = 2'h1;
  localparam logic [1:0] TGD_AXIS_Z = 2'h2;
  localparam int TGD_STS_BUSY_BIT = 3;

  // ---------------------------------------------------------------
  // threshold scaling: code weight 500 mg, sample full scale +-range
  // ---------------------------------------------------------------
  localparam logic [21:0] TGD_LEVEL_WEIGHT = 22'h004000;
  localparam logic [5:0] TGD_RANGE_15G = 6'h0F;
  localparam logic [5:0] TGD_RANGE_30G = 6'h1E;
  localparam logic [5:0] TGD_RANGE_60G = 6'h3C;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int TAP_PULSE_MAX_TIME_STEP_US = 625;
  localparam real TAP_GAP_STEP_MS = 1.25;
  localparam int TAP_PULSE_MAX_TIME_CYC = TAP_PULSE_MAX_TIME_STEP_US * 1000 / CLK_PERIOD_NS;
  localparam int TAP_GAP_CYC = int'($floor(TAP_GAP_STEP_MS * 1000000.0 / CLK_PERIOD_NS));

  // ---------------------------------------------------------------
  // detector states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_PULSE = 5'h02,
    ST_DROP = 5'h04,
    ST_LATENT = 5'h08,
    ST_WINDOW = 5'h10
  } tgd_state_t;

endpackage

// ==== tgd_tick_if.sv ====
// interface: restart and tick between the detector and a tick generator
`timescale 1ns/10ps
interface tgd_tick_if;
  logic restart;
  logic tick;
  modport gen (input restart, output tick);
  modport load (output restart, input tick);
endinterface

// ==== tgd_tick.sv ====
// module: restartable tick generator, one pulse every CYCLES clocks
`timescale 1ns/10ps
module tgd_tick import tgd_pkg::*; #(
  parameter int CYCLES = TAP_GAP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  tgd_tick_if.gen tk
);

  typedef struct packed {
    logic [14:0] cnt;
    logic tick;
  } tgd_tick_reg_t;

  localparam logic [14:0] LAST = 15'(CYCLES - 1);

  tgd_tick_reg_t s;
  tgd_tick_reg_t next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (tk.restart) begin
      next_s.cnt = 15'h0000;
    end else if (s.cnt == LAST) begin
      next_s.cnt = 15'h0000;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 15'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tk.tick = s.tick;

endmodule // tgd_tick

// ==== tgd_sample_src.sv ====
// sample source model feeding the tap detector
`timescale 1ns/10ps
module tgd_sample_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic [1:0] axis,
  input wire logic signed [15:0] mag,
  output logic sample_valid,
  output logic signed [15:0] sample_x,
  output logic signed [15:0] sample_y,
  output logic signed [15:0] sample_z
);
  logic ph;
  logic go;
  assign go = !slow || ph;
  // ----
  // one sample per cycle, or every other cycle when slow
  // ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 1'b0;
      sample_valid <= 1'b0;
      sample_x <= 16'sh0000;
      sample_y <= 16'sh0000;
      sample_z <= 16'sh0000;
    end else begin
      ph <= ~ph;
      sample_valid <= go;
      sample_x <= go ? ((axis == 2'h0) ? mag : 16'sh0000) : ~sample_x;
      sample_y <= go ? ((axis == 2'h1) ? mag : 16'sh0000) : ~sample_y;
      sample_z <= go ? ((axis == 2'h2) ? mag : 16'sh0000) : ~sample_z;
    end
  end
endmodule // tgd_sample_src

// ==== tap_gesture_detector_tb_top.sv ====
// testbench: random and corner tap sequences against the tap detector
`timescale 1ns/10ps
module tap_gesture_detector_tb_top import tgd_pkg::*;;
  localparam int DUR = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, sample_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [1:0] meas_range, axis;
  logic signed [15:0] mag, sample_x, sample_y, sample_z;
  logic single_tap, double_tap, triple_tap, rerr;
  int failures, tests_run, cyc, n_s, n_d, n_t, i, lv;
  tgd_detector #(.DUR_TICK_CYC(10), .GAP_TICK_CYC(20)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
    .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z), .meas_range(meas_range),
    .single_tap(single_tap), .double_tap(double_tap), .triple_tap(triple_tap));
  tgd_sample_src src (.pclk(pclk), .presetn(presetn), .slow(slow), .axis(axis), .mag(mag),
    .sample_valid(sample_valid), .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z));
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    n_s += (single_tap === 1'b1);
    n_d += (double_tap === 1'b1);
    n_t += (triple_tap === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      failures++;
      $display("timeout");
      conclude();
    end
  end
  // ----
  // helpers
  // ----
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic int rmul(input logic [1:0] r);
    return (r == 2'h0) ? 15 : (r == 2'h1) ? 30 : 60;
  endfunction
  function automatic void expect_taps(input int n, input bit chain, input bit trip_en,
      output int s, output int d, output int t);
    int rank;
    rank = 0; s = 0; d = 0; t = 0;
    for (int k = 0; k < n; k++) begin
      rank = (chain && rank > 0 && rank < (trip_en ? 3 : 2)) ? rank + 1 : 1;
      s += (rank == 1);
      d += (rank == 2);
      t += (rank == 3);
    end
  endfunction
  task automatic scen(input string nm, input int l, d, q, w, s, ax, n, hi, gap, off);
    int es, ed, et, s0, d0, t0, a, r;
    bit ok;
    r = $urandom_range(2, 0);
    a = l * 16384 / rmul(2'(r)) + off;
    if (a > 32767) a = 32767;
    ok = l != 0 && s[1:0] == ax && hi < (d + 1) * DUR && a * rmul(2'(r)) > l * 16384;
    expect_taps(ok ? n : 0, q != 0 && gap < 60, s[2], es, ed, et);
    apb(1'b1, TGD_IDX_LEVEL, 32'(l));
    apb(1'b1, TGD_IDX_DUR, 32'(d));
    apb(1'b1, TGD_IDX_QUIET, 32'(q));
    apb(1'b1, TGD_IDX_WIN, 32'(w));
    apb(1'b1, TGD_IDX_SETUP, 32'(s));
    s0 = n_s; d0 = n_d; t0 = n_t;
    meas_range <= 2'(r);
    axis <= 2'(ax);
    slow <= 1'($urandom_range(1, 0));
    for (int k = 0; k < n; k++) begin
      @(posedge pclk);
      mag <= $urandom_range(1, 0) ? -16'(a) : 16'(a);
      repeat (hi) @(posedge pclk);
      mag <= 16'sh0000;
      repeat (gap) @(posedge pclk);
    end
    repeat (200) @(posedge pclk);
    chk("single", 32'(n_s - s0), 32'(es));
    chk("double", 32'(n_d - d0), 32'(ed));
    chk("triple", 32'(n_t - t0), 32'(et));
    $display("done %s", nm);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    meas_range = 0; axis = 0; mag = 0; slow = 0;
    failures = 0; tests_run = 0; cyc = 0; n_s = 0; n_d = 0; n_t = 0;
    void'($urandom(32'h9bf8));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 5; i++) begin
      apb(1'b0, TGD_IDX_LEVEL + 10'(i), 32'h0);
      chk("reset", rdata, 32'h0);
      chk("reset_err", 32'(rerr), 32'h0);
      lv = $urandom_range(255, 0);
      apb(1'b1, TGD_IDX_LEVEL + 10'(i), 32'hFFFFFF00 | 32'(lv));
      apb(1'b0, TGD_IDX_LEVEL + 10'(i), 32'h0);
      chk("rdback", rdata, (i == 4) ? 32'(lv & 7) : 32'(lv));
    end
    apb(1'b0, 10'h3FF, 32'h0);
    chk("unmapped", rdata, 32'h0);
    chk("unmapped_err", 32'(rerr), 32'h1);
    $display("done regs");
    lv = $urandom_range(20, 1);
    scen("single", lv, 2, 0, 3, 0, 0, 2, 5, 40, 1);
    scen("at_level", lv, 2, 0, 3, 0, 0, 1, 5, 40, 0);
    scen("level0", 0, 2, 0, 3, 0, 0, 1, 5, 40, 1);
    scen("axis3", lv, 2, 0, 3, 3, 0, 1, 5, 40, 1);
    for (i = 0; i < 3; i++) begin
      scen("axis", lv, 2, 0, 3, i, i, 1, 5, 40, 1);
      scen("other_axis", lv, 2, 0, 3, i, (i + 1) % 3, 1, 5, 40, 1);
    end
    scen("long", lv, 2, 0, 3, 0, 0, 1, 60, 40, 1);
    scen("dur0", lv, 0, 0, 3, 0, 0, 1, 5, 40, 1);
    scen("double", lv, 2, 1, 3, 1, 1, 2, 5, 40, 1);
    scen("late", lv, 2, 1, 3, 0, 0, 2, 5, 150, 1);
    apb(1'b1, TGD_IDX_STATUS, 32'h7);
    scen("triple", lv, 2, 1, 3, 6, 2, 3, 5, 40, 1);
    apb(1'b0, TGD_IDX_STATUS, 32'h0);
    chk("sticky", {rdata[8:4], rdata[2:0]}, 32'h0F);
    apb(1'b1, TGD_IDX_STATUS, 32'h7);
    apb(1'b0, TGD_IDX_STATUS, 32'h0);
    chk("cleared", 32'(rdata[2:0]), 32'h0);
    scen("no_triple", lv, 2, 1, 3, 0, 0, 3, 5, 40, 1);
    scen("max_level", 255, 2, 0, 3, 0, 0, 1, 5, 40, 40000);
    conclude();
  end
endmodule // tap_gesture_detector_tb_top
